// ===== inc/sram_burst_pkg.sv
// shared constants and types of the synchronous sram burst control
// assumes one 200 MHz clock and a four-lane, nine-bit-per-lane data bus
package sram_burst_pkg;

  localparam int ADDR_W  = 18;
  localparam int LANE_N  = 4;
  localparam int LANE_W  = 9;
  localparam int DATA_W  = LANE_N * LANE_W;
  localparam int BURST_W = 2;
  localparam int WR_W    = ADDR_W + DATA_W + LANE_N;
  localparam int BUF_DEPTH = 2;

  localparam logic [BURST_W-1:0] BURST_START = 2'h0;
  localparam logic [BURST_W-1:0] BURST_ONE   = 2'h1;
  localparam logic [ADDR_W-1:0]  ADDR_RESET  = 18'h00000;
  localparam logic [DATA_W-1:0]  DATA_RESET  = 36'h000000000;
  localparam logic [LANE_N-1:0]  LANES_NONE  = 4'h0;

  // low address bit position of the burst field
  localparam int BURST_LSB = 0;

  typedef enum logic [2:0] {
    ST_DESEL = 3'h1,
    ST_READ  = 3'h2,
    ST_WRITE = 3'h4
  } burst_state_type;

endpackage

// ===== core/sram_burst_addr.sv
// burst address generator: loaded address plus two-bit burst count
// assumes the caller gives load and step only on edges it really takes
module sram_burst_addr
  import sram_burst_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              load,
  input  wire logic              step,
  input  wire logic              burstOrderSelect,
  input  wire logic [ADDR_W-1:0] loadAddr,
  output logic      [ADDR_W-1:0] nextAddr
);

  logic [ADDR_W-1:0]  base_q;
  logic [BURST_W-1:0] count_q;
  logic [BURST_W-1:0] count_d;
  logic [BURST_W-1:0] low;

  // two-bit counter wraps back to the loaded address every fourth cycle
  assign count_d = count_q + BURST_ONE;

  always_comb begin
    if (burstOrderSelect) begin
      low = base_q[BURST_LSB +: BURST_W] ^ count_d;
    end else begin
      low = base_q[BURST_LSB +: BURST_W] + count_d;
    end
  end

  assign nextAddr = {base_q[ADDR_W-1:BURST_W], low};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      base_q  <= ADDR_RESET;
      count_q <= BURST_START;
    end else if (load) begin
      base_q  <= loadAddr;
      count_q <= BURST_START;
    end else if (step) begin
      count_q <= count_d;
    end
  end

endmodule

// ===== core/sram_two_entry_buf.sv
// two-entry buffer with valid and ready on both sides
// assumes the drain side may stall for any number of cycles
module sram_two_entry_buf
  import sram_burst_pkg::*;
#(
  parameter int WIDTH = WR_W
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  logic [WIDTH-1:0] mem_q [BUF_DEPTH];
  logic             wrPtr_q;
  logic             rdPtr_q;
  logic [1:0]       count_q;
  logic             push;
  logic             pop;

  assign inReady  = (count_q != 2'h2);
  assign outValid = (count_q != 2'h0);
  assign outData  = mem_q[rdPtr_q];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) begin
        wrPtr_q <= ~wrPtr_q;
      end
      if (pop) begin
        rdPtr_q <= ~rdPtr_q;
      end
      if (push && !pop) begin
        count_q <= count_q + 2'h1;
      end else if (pop && !push) begin
        count_q <= count_q - 2'h1;
      end
    end
  end

endmodule

// ===== core/sram_burst_ctl.sv
// command, burst and byte-write control of a pipelined synchronous sram
// assumes a host on the same clock; the array sits behind the array ports
//
// How it works
// - burst order high: next low address bits are loaded bits xor count
// - burst order low: low two address bits count upward, wrapping at four
// - two-bit burst counter returns to the start address every fourth cycle
// - every continue-burst cycle inside a read or write burst advances the address counter
// - continuation keeps the direction from the load cycle, read/write ignored
// - advance after a deselect stays deselected, bus high-impedance
// - each low lane write enable writes its own lane, any mix allowed
// - write with all lane enables high writes nothing, counter still runs
// - read with output enable high sequences normally, data pins stay off
// - data drivers switch off during writes by themselves
// - clock gate high makes the edge ignored, burst, state and pipeline registers held
// - ignored edge keeps read drive, keeps write high-z, pushes no write; already buffered writes still drain to the array
// - state machine changes only on rising clock edges
// - synchronous inputs are taken on the rising clock edge
// - data outputs high-impedance from reset until a read drives them
// - advance high steps the burst; advance low loads a new address
// - output enable gates the data drivers directly, without the clock
module sram_burst_ctl
  import sram_burst_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              primarySelectN,
  input  wire logic              secondSelectN,
  input  wire logic              thirdSelectHigh,
  input  wire logic              advanceNotLoad,
  input  wire logic              readNotWrite,
  input  wire logic              laneAWriteEnableN,
  input  wire logic              laneBWriteEnableN,
  input  wire logic              laneCWriteEnableN,
  input  wire logic              laneDWriteEnableN,
  input  wire logic              clockEnableN,
  input  wire logic              outputEnableN,
  input  wire logic              sleepRequest,
  input  wire logic              burstOrderSelect,
  input  wire logic [DATA_W-1:0] dqIn,
  output logic      [DATA_W-1:0] dqOut,
  output logic      [LANE_N-1:0] dqOe,
  output logic      [ADDR_W-1:0] arrayRdAddr,
  output logic                   arrayRdEn,
  input  wire logic [DATA_W-1:0] arrayRdData,
  output logic                   arrayWrValid,
  input  wire logic              arrayWrReady,
  output logic      [ADDR_W-1:0] arrayWrAddr,
  output logic      [DATA_W-1:0] arrayWrData,
  output logic      [LANE_N-1:0] arrayWrLaneEn,
  output logic                   sleeping
);

  burst_state_type state_q;
  burst_state_type state_d;

  // sleep arrives without the clock and is resynchronised
  logic sleepMeta_q;
  logic sleepSync_q;

  // stage 1: command accepted, array read issued at the next edge
  logic              s1Valid_q;
  logic              s1Read_q;
  logic [ADDR_W-1:0] s1Addr_q;
  logic [LANE_N-1:0] s1Lanes_q;

  // stage 2: data cycle on the bus
  logic              s2Valid_q;
  logic              s2Read_q;
  logic [ADDR_W-1:0] s2Addr_q;
  logic [LANE_N-1:0] s2Lanes_q;

  logic              drive_q;
  logic [DATA_W-1:0] dqOut_q;

  logic              edgeTaken;
  logic              wrWant;
  logic              bufReady;
  logic              stall;
  logic              advance;
  logic              loadCycle;
  logic              selected;
  logic              burstStep;
  logic              cmdValid;
  logic              cmdRead;
  logic [ADDR_W-1:0] cmdAddr;
  logic [ADDR_W-1:0] burstAddr;
  logic [LANE_N-1:0] laneEn;
  logic [WR_W-1:0]   wrPacked;
  logic [WR_W-1:0]   wrOut;

  // edge is ignored while the clock gate is high or the device sleeps
  assign edgeTaken = ~clockEnableN & ~sleepSync_q;

  // a write that cannot reach the buffer freezes the pipeline
  assign wrWant  = s2Valid_q & ~s2Read_q & (|s2Lanes_q);
  assign stall   = wrWant & ~bufReady;
  assign advance = edgeTaken & ~stall;

  assign loadCycle = ~advanceNotLoad;
  assign selected  = ~primarySelectN & ~secondSelectN & thirdSelectHigh;

  // continuation steps the counter only inside a read or write burst
  assign burstStep = advance & advanceNotLoad & (state_q != ST_DESEL);

  assign laneEn = ~{laneDWriteEnableN, laneCWriteEnableN,
                    laneBWriteEnableN, laneAWriteEnableN};

  always_comb begin
    cmdValid = 1'b0;
    cmdRead  = 1'b0;
    cmdAddr  = burstAddr;
    if (loadCycle) begin
      cmdValid = selected;
      cmdRead  = readNotWrite;
      cmdAddr  = address;
    end else begin
      cmdValid = (state_q != ST_DESEL);
      cmdRead  = (state_q == ST_READ);
    end
  end

  // only a load cycle picks a new state; continuation keeps the current one
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_DESEL, ST_READ, ST_WRITE: begin
        if (loadCycle) begin
          if (!selected) begin
            state_d = ST_DESEL;
          end else if (readNotWrite) begin
            state_d = ST_READ;
          end else begin
            state_d = ST_WRITE;
          end
        end
      end
      default: begin
        state_d = ST_DESEL;
      end
    endcase
  end

  sram_burst_addr u_burst (
    .clk              (clk),
    .rst_b            (rst_b),
    .load             (advance & loadCycle & selected),
    .step             (burstStep),
    .burstOrderSelect (burstOrderSelect),
    .loadAddr         (address),
    .nextAddr         (burstAddr)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sleepMeta_q <= 1'b0;
      sleepSync_q <= 1'b0;
    end else begin
      sleepMeta_q <= sleepRequest;
      sleepSync_q <= sleepMeta_q;
    end
  end

  // state machine, held on ignored edges and forced idle in sleep
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_DESEL;
    end else if (sleepSync_q) begin
      state_q <= ST_DESEL;
    end else if (advance) begin
      state_q <= state_d;
    end
  end

  // command stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1Valid_q <= 1'b0;
      s1Read_q  <= 1'b0;
      s1Addr_q  <= ADDR_RESET;
      s1Lanes_q <= LANES_NONE;
    end else if (sleepSync_q) begin
      s1Valid_q <= 1'b0;
    end else if (advance) begin
      s1Valid_q <= cmdValid;
      s1Read_q  <= cmdRead;
      s1Addr_q  <= cmdAddr;
      s1Lanes_q <= cmdRead ? LANES_NONE : laneEn;
    end
  end

  // data stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s2Valid_q <= 1'b0;
      s2Read_q  <= 1'b0;
      s2Addr_q  <= ADDR_RESET;
      s2Lanes_q <= LANES_NONE;
    end else if (sleepSync_q) begin
      s2Valid_q <= 1'b0;
    end else if (advance) begin
      s2Valid_q <= s1Valid_q;
      s2Read_q  <= s1Read_q;
      s2Addr_q  <= s1Addr_q;
      s2Lanes_q <= s1Lanes_q;
    end
  end

  // array read is issued one edge after the command, data is on the pins after two
  assign arrayRdEn   = s1Valid_q & s1Read_q & advance;
  assign arrayRdAddr = s1Addr_q;

  // output register and driver enable; writes turn the drivers off
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      drive_q <= 1'b0;
      dqOut_q <= DATA_RESET;
    end else if (sleepSync_q) begin
      drive_q <= 1'b0;
    end else if (advance) begin
      drive_q <= s2Valid_q & s2Read_q;
      if (s2Valid_q && s2Read_q) begin
        dqOut_q <= arrayRdData;
      end
    end
  end

  // clock-gated and stalled edges leave drive_q untouched, so a read keeps driving; sleep clears it
  assign dqOut = dqOut_q;
  assign dqOe  = {LANE_N{drive_q & ~outputEnableN & ~sleepSync_q}};

  // write data is taken at the data edge; an abort is never pushed
  assign wrPacked = {s2Addr_q, dqIn, s2Lanes_q};

  sram_two_entry_buf #(
    .WIDTH (WR_W)
  ) u_wrbuf (
    .clk      (clk),
    .rst_b    (rst_b),
    .inValid  (wrWant & edgeTaken),
    .inReady  (bufReady),
    .inData   (wrPacked),
    .outValid (arrayWrValid),
    .outReady (arrayWrReady),
    .outData  (wrOut)
  );

  assign arrayWrAddr   = wrOut[WR_W-1 -: ADDR_W];
  assign arrayWrData   = wrOut[LANE_N +: DATA_W];
  assign arrayWrLaneEn = wrOut[LANE_N-1:0];

  assign sleeping = sleepSync_q;

endmodule

// ===== verif/sram_burst_ctl_checker.sv
// port assertions of the burst control
// assumes binding to sram_burst_ctl, one clock, rst_b active low
module sram_burst_ctl_checker
  import sram_burst_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic [ADDR_W-1:0] address,
  input wire logic              primarySelectN,
  input wire logic              secondSelectN,
  input wire logic              thirdSelectHigh,
  input wire logic              advanceNotLoad,
  input wire logic              readNotWrite,
  input wire logic              laneAWriteEnableN,
  input wire logic              clockEnableN,
  input wire logic              outputEnableN,
  input wire logic [DATA_W-1:0] dqOut,
  input wire logic [LANE_N-1:0] dqOe,
  input wire logic [ADDR_W-1:0] arrayRdAddr,
  input wire logic              arrayRdEn,
  input wire logic [DATA_W-1:0] arrayRdData,
  input wire logic              arrayWrValid,
  input wire logic              sleeping
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic tk;
  logic sel;
  logic ld;
  assign tk  = !clockEnableN && !sleeping;
  assign sel = !primarySelectN && !secondSelectN && thirdSelectHigh;
  // empty write buffer rules out a stalled edge
  assign ld  = tk && !advanceNotLoad && !arrayWrValid;
  sequence rd_issue;
    ld && sel && readNotWrite ##1 tk;
  endsequence
  sequence wr_issue;
    ld && sel && !readNotWrite ##1 tk;
  endsequence
  AST_RD_ADDR:
  assert property (rd_issue |-> arrayRdEn && arrayRdAddr == $past(address)) else $error("no read");
  AST_RD_DATA:
  assert property (arrayRdEn && tk ##1 tk |=> dqOut == $past(arrayRdData)) else $error("bad data");
  // the write reaches the data stage one taken edge after issue, drivers drop at the next
  AST_WR_OFF:
  assert property (wr_issue ##1 tk |=> dqOe == LANES_NONE) else $error("drive in write");
  AST_WR_PUSH:
  assert property (wr_issue ##0 !$past(laneAWriteEnableN) ##1 tk |=> arrayWrValid)
    else $error("write lost");
  AST_DESEL:
  assert property (ld && !sel ##1 tk |-> !arrayRdEn ##2 (!$past(tk) || dqOe == LANES_NONE))
    else $error("deselect read");
  AST_OE:
  assert property (outputEnableN |-> dqOe == LANES_NONE) else $error("drive with oe high");
  AST_SLEEP:
  assert property (sleeping |-> dqOe == LANES_NONE) else $error("drive in sleep");
  AST_HOLD:
  assert property (clockEnableN && !sleeping |=> $stable(dqOut) && $stable(arrayRdAddr)
    && (sleeping || $changed(outputEnableN) || $stable(dqOe)))
    else $error("ignored edge changed state");
  AST_RST:
  assert property (disable iff (1'b0) !rst_b |-> dqOe == LANES_NONE && !arrayWrValid)
    else $error("active in reset");
endmodule

// ===== verif/sram_host_model.sv
// host controller model: commands, write data two taken edges late, read capture
// assumes the bench calls cmd and set; everything changes just after posedge
module sram_host_model
  import sram_burst_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [DATA_W-1:0] dqOut,
  input  wire logic [LANE_N-1:0] dqOe,
  output logic      [ADDR_W-1:0] address,
  output logic                   primarySelectN,
  output logic                   secondSelectN,
  output logic                   thirdSelectHigh,
  output logic                   advanceNotLoad,
  output logic                   readNotWrite,
  output logic                   laneAWriteEnableN,
  output logic                   laneBWriteEnableN,
  output logic                   laneCWriteEnableN,
  output logic                   laneDWriteEnableN,
  output logic                   clockEnableN,
  output logic                   outputEnableN,
  output logic                   sleepRequest,
  output logic                   burstOrderSelect,
  output logic      [DATA_W-1:0] dqIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] p1 = DATA_RESET;
  logic [DATA_W-1:0] p2 = DATA_RESET;
  logic              tkPrev = 1'b0;
  logic [DATA_W-1:0] got[$];
  initial begin
    {primarySelectN, secondSelectN, thirdSelectHigh, advanceNotLoad, readNotWrite} = 5'h19;
    {laneDWriteEnableN, laneCWriteEnableN, laneBWriteEnableN, laneAWriteEnableN} = 4'hf;
    {clockEnableN, outputEnableN, sleepRequest, burstOrderSelect} = 4'h1;
    address = ADDR_RESET;
    dqIn = DATA_RESET;
  end
  // capture only words launched by a taken edge
  always @(posedge clk) begin
    if (tkPrev && dqOe === {LANE_N{1'b1}})
      got.push_back(dqOut);
    tkPrev <= !clockEnableN;
  end
  task automatic cmd(input logic [2:0] s, input logic adv, input logic rnw,
                     input logic [ADDR_W-1:0] a, input logic [LANE_N-1:0] bwN,
                     input logic [DATA_W-1:0] d, input logic cen);
    @(posedge clk);
    {primarySelectN, secondSelectN, thirdSelectHigh} <= s;
    advanceNotLoad <= adv;
    readNotWrite <= rnw;
    address <= a;
    {laneDWriteEnableN, laneCWriteEnableN, laneBWriteEnableN, laneAWriteEnableN} <= bwN;
    clockEnableN <= cen;
    dqIn <= p2;
    if (!cen) begin
      p2 = p1;
      p1 = d;
    end
  endtask
  task automatic set(input logic oe, input logic zz, input logic bo);
    @(posedge clk);
    outputEnableN <= oe;
    sleepRequest <= zz;
    burstOrderSelect <= bo;
  endtask
endmodule

// ===== verif/tb.sv
// self-checking bench: host model, array model, checker bound to the control
// assumes the package and the design files are compiled first
module tb
  import sram_burst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // low bits 01 make the linear and interleaved orders differ
  localparam logic [ADDR_W-1:0] BASE = 18'h00125;
  logic                  clk = 1'b0;
  logic                  rst_b = 1'b0;
  logic                  arrayStall = 1'b0;
  logic     [ADDR_W-1:0] address, arrayRdAddr, arrayWrAddr;
  logic                  primarySelectN, secondSelectN, thirdSelectHigh, advanceNotLoad;
  logic                  readNotWrite, clockEnableN, outputEnableN, sleepRequest;
  logic                  laneAWriteEnableN, laneBWriteEnableN, laneCWriteEnableN;
  logic                  laneDWriteEnableN, burstOrderSelect, sleeping;
  logic                  arrayRdEn, arrayWrValid, arrayWrReady;
  logic     [DATA_W-1:0] dqIn, dqOut, arrayWrData;
  logic     [DATA_W-1:0] arrayRdData = DATA_RESET;
  logic     [LANE_N-1:0] dqOe, arrayWrLaneEn;
  logic     [DATA_W-1:0] mem [2**ADDR_W];
  int                    failures = 0;
  int                    checksDone = 0;
  sram_burst_ctl i_sram_burst_ctl (.*);
  sram_host_model i_sram_host_model (.*);
  initial begin
    forever #2.5 clk = ~clk;
  end
  assign arrayWrReady = !arrayStall;
  always @(posedge clk) begin
    if (arrayRdEn)
      arrayRdData <= mem[arrayRdAddr];
    if (arrayWrValid && arrayWrReady)
      for (int k = 0; k < LANE_N; k++)
        if (arrayWrLaneEn[k])
          mem[arrayWrAddr][k*LANE_W +: LANE_W] = arrayWrData[k*LANE_W +: LANE_W];
  end
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checksDone++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic op(input logic [2:0] s, input logic adv, input logic rnw,
                    input logic [ADDR_W-1:0] a, input logic [LANE_N-1:0] bwN,
                    input logic [DATA_W-1:0] d);
    i_sram_host_model.cmd(s, adv, rnw, a, bwN, d, 1'b0);
  endtask
  // deselects flush the pipeline, then the write buffer must empty
  task automatic settle;
    int n;
    repeat (4) op(3'h7, 1'b0, 1'b1, BASE, 4'hf, DATA_RESET);
    while (arrayWrValid && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (arrayWrValid) begin
      failures++;
      end_sim();
    end
    // let captures of the last edge finish before anyone looks
    @(negedge clk);
  endtask
  task automatic t_burst(input logic ord);
    logic [ADDR_W-1:0] a [4];
    logic [DATA_W-1:0] d [4];
    i_sram_host_model.set(1'b0, 1'b0, ord);
    for (int i = 0; i < 4; i++) begin
      a[i] = ord ? BASE ^ ADDR_W'(i) : {BASE[ADDR_W-1:2], 2'(BASE[1:0] + 2'(i))};
      d[i] = {LANE_N{9'h0b3 + 9'(i) + 9'(ord)}};
      op(3'h1, i != 0, i != 0, BASE, LANES_NONE, d[i]);
      if (i == 1)
        i_sram_host_model.cmd(3'h1, 1'b1, 1'b1, BASE, 4'hf, DATA_RESET, 1'b1);
    end
    settle();
    for (int i = 0; i < 4; i++)
      chk(mem[a[i]], d[i]);
    i_sram_host_model.got.delete();
    for (int i = 0; i < 5; i++) begin
      op(3'h1, i != 0, i == 0, BASE, LANES_NONE, DATA_RESET);
      if (i == 3)
        i_sram_host_model.cmd(3'h1, 1'b1, 1'b0, BASE, 4'hf, DATA_RESET, 1'b1);
    end
    settle();
    chk(DATA_W'(i_sram_host_model.got.size()), 36'h5);
    for (int i = 0; i < 5; i++)
      chk(i_sram_host_model.got[i], d[i % 4]);
    $display("burst test done, order %0d", ord);
  endtask
  task automatic t_lanes;
    logic [DATA_W-1:0] w;
    w = DATA_RESET;
    op(3'h1, 1'b0, 1'b0, 18'h00300, LANES_NONE, DATA_RESET);
    for (int k = 0; k < LANE_N; k++) begin
      op(3'h1, 1'b0, 1'b0, 18'h00300, ~(4'h1 << k), {LANE_N{9'h1c1 + 9'(k)}});
      w[k*LANE_W +: LANE_W] = 9'h1c1 + 9'(k);
    end
    op(3'h1, 1'b0, 1'b0, 18'h00300, 4'hf, {DATA_W{1'b1}});
    settle();
    chk(mem[18'h00300], w);
    arrayStall <= 1'b1;
    op(3'h1, 1'b0, 1'b0, 18'h00301, LANES_NONE, 36'h123456789);
    op(3'h1, 1'b0, 1'b0, 18'h00302, LANES_NONE, 36'h0abcdef01);
    repeat (4) op(3'h7, 1'b0, 1'b1, BASE, 4'hf, DATA_RESET);
    chk(DATA_W'({arrayWrValid, arrayWrAddr}), {17'h0, 1'b1, 18'h00301});
    arrayStall <= 1'b0;
    settle();
    chk(mem[18'h00301], 36'h123456789);
    chk(mem[18'h00302], 36'h0abcdef01);
    $display("lane test done");
  endtask
  task automatic t_quiet;
    logic [2:0] s [3];
    s = '{3'h5, 3'h3, 3'h0};
    i_sram_host_model.got.delete();
    i_sram_host_model.set(1'b1, 1'b0, 1'b0);
    op(3'h1, 1'b0, 1'b1, BASE, 4'hf, DATA_RESET);
    op(3'h1, 1'b1, 1'b1, BASE, 4'hf, DATA_RESET);
    settle();
    i_sram_host_model.set(1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 3; i++) begin
      op(s[i], 1'b0, 1'b1, BASE, 4'hf, DATA_RESET);
      op(3'h1, 1'b1, 1'b1, BASE, 4'hf, DATA_RESET);
    end
    settle();
    chk(DATA_W'(i_sram_host_model.got.size()), DATA_RESET);
    $display("quiet test done");
  endtask
  task automatic t_sleep;
    i_sram_host_model.got.delete();
    i_sram_host_model.set(1'b0, 1'b1, 1'b1);
    repeat (4) op(3'h7, 1'b0, 1'b1, BASE, 4'hf, DATA_RESET);
    chk(DATA_W'(sleeping), 36'h1);
    repeat (3) op(3'h1, 1'b0, 1'b1, BASE, 4'hf, DATA_RESET);
    i_sram_host_model.set(1'b0, 1'b0, 1'b1);
    settle();
    chk(DATA_W'(i_sram_host_model.got.size()), DATA_RESET);
    $display("sleep test done");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    chk(DATA_W'({dqOe, arrayWrValid}), DATA_RESET);
    t_burst(1'b1);
    t_burst(1'b0);
    t_lanes();
    t_quiet();
    t_sleep();
    end_sim();
  end
endmodule
bind sram_burst_ctl sram_burst_ctl_checker i_sram_burst_ctl_checker (.*);
